// file: hcp_cmd_port.v
// What this block does
// RULE_01 - Answer only slave address 0x70
// RULE_02 - Master sends only documented command codes
// RULE_03 - Two identifier reads, each with checksum
// RULE_04 - Decode soft reset, heater write, heater read
// RULE_05 - Four measurement codes pick speed and handshake
// RULE_06 - Query 0x80 0x5D acked, no effect
// RULE_07 - Query 0xEF 0xC8 returns three fixed bytes
// RULE_08 - Command 0x84 0xF1 returns firmware revision
// RULE_09 - Hold stretches clock, no-hold refuses reads
// RULE_10 - No-hold NACKs read address until done
// RULE_11 - Checksum after each LSB, CRC-8 init 0xFC
// RULE_12 - User register read has no checksum
// RULE_13 - Two-byte codes act after second byte
`timescale 1ns/1ns
`include "hcp_defines.vh"

module hcp_cmd_port #(
	parameter [7:0]  FW_REV    = `HCP_FW_REV,
	parameter [23:0] QUERY_ID  = 24'h3c5aa5 // Arbitrary value
) (
	input  wire        mclk_in,
	input  wire        rst_n_in,
	input  wire        ce_in,
	input  wire        scl_in,
	input  wire        sda_in,
	output wire        scl_out,
	output reg         scl_oe_out,
	output wire        sda_out,
	output reg         sda_oe_out,
	output reg         meas_start_out,
	output reg         meas_fast_out,
	input  wire        meas_done_in,
	input  wire [15:0] meas_temp_in,
	input  wire [15:0] meas_hum_in,
	input  wire [31:0] eid_a_in,
	input  wire [31:0] eid_b_in,
	output reg         soft_reset_out,
	output wire [7:0]  heater_out
);

	// ****************************************
	// States and response kinds
	// ****************************************
	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_ADDR  = 3'h1;
	localparam [2:0] S_ACK   = 3'h2;
	localparam [2:0] S_WR    = 3'h3;
	localparam [2:0] S_RD    = 3'h4;
	localparam [2:0] S_RACK  = 3'h5;
	localparam [2:0] S_RNXT  = 3'h6;
	localparam [2:0] S_HOLD  = 3'h7;

	localparam [2:0] R_NONE  = 3'h0;
	localparam [2:0] R_MEAS  = 3'h1;
	localparam [2:0] R_EIDA  = 3'h2;
	localparam [2:0] R_EIDB  = 3'h3;
	localparam [2:0] R_HTR   = 3'h4;
	localparam [2:0] R_FW    = 3'h5;
	localparam [2:0] R_QID   = 3'h6;

	reg  [2:0]  scl_sync_q;
	reg  [2:0]  sda_sync_q;
	reg         scl_f_q;
	reg         scl_p_q;
	reg         sda_f_q;
	reg         sda_p_q;
	reg  [2:0]  state_q;
	reg  [3:0]  cnt_q;
	reg  [7:0]  shift_q;
	reg  [7:0]  tx_q;
	reg         rd_q;
	reg  [1:0]  widx_q;
	reg  [7:0]  cmd0_q;
	reg  [2:0]  resp_q;
	reg  [2:0]  bidx_q;
	reg  [7:0]  crc_q;
	reg         busy_q;
	reg         hold_q;
	reg  [7:0]  heater_q;
	reg  [15:0] temp_q;
	reg  [15:0] hum_q;
	reg  [7:0]  tx_byte;
	reg         tx_crc;
	wire [7:0]  crc_next;
	wire        scl_rise;
	wire        scl_fall;
	wire        start_det;
	wire        stop_det;
	wire [15:0] cmd_pair;

	// Open-drain: only ever pull low
	assign scl_out    = 1'b0;
	assign sda_out    = 1'b0;
	assign heater_out = heater_q;

	// Edges of the filtered bus lines
	assign scl_rise  = scl_f_q & ~scl_p_q;
	assign scl_fall  = ~scl_f_q & scl_p_q;
	assign start_det = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
	assign stop_det  = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;
	assign cmd_pair  = {cmd0_q, shift_q};

	// ****************************************
	// Reply byte selection
	// ****************************************

	// Checksum only follows measurement and identifier words
	always @* begin
		tx_byte = `HCP_IDLE_BYTE;
		tx_crc  = 1'b0;
		case (resp_q)
			R_MEAS: begin
				case (bidx_q)
					3'h0: tx_byte = temp_q[15:8];
					3'h1: tx_byte = temp_q[7:0];
					3'h2: tx_crc  = 1'b1; // RULE_11
					3'h3: tx_byte = hum_q[15:8];
					3'h4: tx_byte = hum_q[7:0];
					3'h5: tx_crc  = 1'b1; // RULE_11
					default: tx_byte = `HCP_IDLE_BYTE;
				endcase
			end
			R_EIDA, R_EIDB: begin
				case (bidx_q)
					3'h0: tx_byte = (resp_q == R_EIDA) ?
						eid_a_in[31:24] : eid_b_in[31:24]; // RULE_03
					3'h1: tx_byte = (resp_q == R_EIDA) ?
						eid_a_in[23:16] : eid_b_in[23:16];
					3'h2: tx_byte = (resp_q == R_EIDA) ?
						eid_a_in[15:8] : eid_b_in[15:8];
					3'h3: tx_byte = (resp_q == R_EIDA) ?
						eid_a_in[7:0] : eid_b_in[7:0];
					3'h4: tx_crc  = 1'b1; // RULE_03
					default: tx_byte = `HCP_IDLE_BYTE;
				endcase
			end
			R_HTR: begin
				if (bidx_q == 3'h0) begin
					tx_byte = heater_q; // RULE_12
				end
			end
			R_FW: begin
				if (bidx_q == 3'h0) begin
					tx_byte = FW_REV; // RULE_08
				end
			end
			R_QID: begin
				case (bidx_q)
					3'h0: tx_byte = QUERY_ID[23:16]; // RULE_07
					3'h1: tx_byte = QUERY_ID[15:8];
					3'h2: tx_byte = QUERY_ID[7:0];
					default: tx_byte = `HCP_IDLE_BYTE;
				endcase
			end
			default: tx_byte = `HCP_IDLE_BYTE;
		endcase
		if (tx_crc) begin
			tx_byte = crc_q;
		end
	end

	hcp_crc8 u_crc (
		.crc_in  (crc_q),
		.data_in (tx_byte),
		.crc_out (crc_next)
	);

	// ****************************************
	// Bus engine and command decoder
	// ****************************************

	// Bit timing follows the filtered lines, so a bus level shorter
	// than two enabled master clock cycles is dropped, edge and all
	always @(posedge mclk_in) begin
		if (!rst_n_in) begin
			scl_sync_q     <= 3'h7;
			sda_sync_q     <= 3'h7;
			scl_f_q        <= 1'b1;
			scl_p_q        <= 1'b1;
			sda_f_q        <= 1'b1;
			sda_p_q        <= 1'b1;
			state_q        <= S_IDLE;
			cnt_q          <= 4'h0;
			shift_q        <= 8'h00;
			tx_q           <= 8'hff;
			rd_q           <= 1'b0;
			widx_q         <= 2'h0;
			cmd0_q         <= 8'h00;
			resp_q         <= R_NONE;
			bidx_q         <= 3'h0;
			crc_q          <= `HCP_CRC_INIT;
			busy_q         <= 1'b0;
			hold_q         <= 1'b0;
			heater_q       <= `HCP_HEATER_RST;
			temp_q         <= 16'h0000;
			hum_q          <= 16'h0000;
			scl_oe_out     <= 1'b0;
			sda_oe_out     <= 1'b0;
			meas_start_out <= 1'b0;
			meas_fast_out  <= 1'b0;
			soft_reset_out <= 1'b0;
		end else if (ce_in) begin
			// Change counts once stages two and three agree
			scl_sync_q <= {scl_sync_q[1:0], scl_in};
			sda_sync_q <= {sda_sync_q[1:0], sda_in};
			if (scl_sync_q[1] == scl_sync_q[2]) begin
				scl_f_q <= scl_sync_q[2];
			end
			if (sda_sync_q[1] == sda_sync_q[2]) begin
				sda_f_q <= sda_sync_q[2];
			end
			scl_p_q        <= scl_f_q;
			sda_p_q        <= sda_f_q;
			meas_start_out <= 1'b0;
			soft_reset_out <= 1'b0;
			// Result latched when the engine finishes
			if (meas_done_in) begin
				busy_q <= 1'b0;
				temp_q <= meas_temp_in;
				hum_q  <= meas_hum_in;
			end
			if (start_det) begin
				state_q    <= S_ADDR;
				cnt_q      <= 4'h0;
				sda_oe_out <= 1'b0;
				scl_oe_out <= 1'b0;
			end else if (stop_det) begin
				state_q    <= S_IDLE;
				sda_oe_out <= 1'b0;
				scl_oe_out <= 1'b0;
			end else begin
				case (state_q)
					S_ADDR, S_WR: begin
						if (scl_rise) begin
							shift_q <= {shift_q[6:0], sda_f_q};
							cnt_q   <= cnt_q + 4'h1;
						end else if (scl_fall && cnt_q == 4'h8) begin
							if (state_q == S_ADDR) begin
								if (shift_q[7:1] != `HCP_SLAVE_ADDR) begin
									state_q <= S_IDLE; // RULE_01
								end else if (shift_q[0] && busy_q && !hold_q) begin
									state_q <= S_IDLE; // RULE_10
								end else begin
									sda_oe_out <= 1'b1;
									rd_q       <= shift_q[0];
									widx_q     <= 2'h0;
									state_q    <= S_ACK;
								end
							end else begin
								sda_oe_out <= 1'b1;
								state_q    <= S_ACK;
								if (widx_q != 2'h3) begin
									widx_q <= widx_q + 2'h1;
								end
								if (widx_q == 2'h0) begin
									cmd0_q <= shift_q;
									case (shift_q)
										`HCP_CMD_SOFT_RST: begin
											soft_reset_out <= 1'b1; // RULE_04
											heater_q       <= `HCP_HEATER_RST;
											resp_q         <= R_NONE;
										end
										`HCP_CMD_HTR_RD: begin
											resp_q <= R_HTR; // RULE_04
											bidx_q <= 3'h0;
										end
										default: cmd0_q <= shift_q;
									endcase
								end else if (widx_q == 2'h1) begin
									bidx_q <= 3'h0;
									crc_q  <= `HCP_CRC_INIT;
									// Second byte completes the code
									if (cmd0_q == `HCP_CMD_HTR_WR) begin
										heater_q <= shift_q; // RULE_04
									end else begin
										case (cmd_pair) // RULE_13
											`HCP_CMD_EID_A: resp_q <= R_EIDA; // RULE_03
											`HCP_CMD_EID_B: resp_q <= R_EIDB; // RULE_03
											`HCP_CMD_MEAS_NH,
											`HCP_CMD_MEAS_NN,
											`HCP_CMD_MEAS_FH,
											`HCP_CMD_MEAS_FN: begin
												resp_q         <= R_MEAS; // RULE_05
												busy_q         <= 1'b1;
												meas_start_out <= 1'b1;
												meas_fast_out  <= ~cmd0_q[4]; // Fast codes clear bit 4
												hold_q         <= cmd0_q[2];
											end
											`HCP_CMD_QRY_NOP: resp_q <= R_NONE; // RULE_06
											`HCP_CMD_QRY_ID:  resp_q <= R_QID; // RULE_07
											`HCP_CMD_FW_REV:  resp_q <= R_FW; // RULE_08
											default: resp_q <= R_NONE;
										endcase
									end
								end
							end
						end
					end
					S_ACK: begin
						if (scl_fall) begin
							sda_oe_out <= 1'b0;
							cnt_q      <= 4'h0;
							if (!rd_q) begin
								state_q <= S_WR;
							end else if (busy_q) begin
								scl_oe_out <= 1'b1; // RULE_09
								state_q    <= S_HOLD;
							end else begin
								state_q <= S_RNXT;
							end
						end
					end
					S_HOLD: begin
						// Low bus clock until the result is in
						if (!busy_q) begin
							state_q <= S_RNXT; // RULE_09
						end
					end
					S_RD: begin
						scl_oe_out <= 1'b0;
						if (scl_rise) begin
							cnt_q <= cnt_q + 4'h1;
						end else if (scl_fall) begin
							if (cnt_q == 4'h8) begin
								sda_oe_out <= 1'b0;
								state_q    <= S_RACK;
							end else begin
								tx_q       <= {tx_q[6:0], 1'b1};
								sda_oe_out <= ~tx_q[6];
							end
						end
					end
					S_RACK: begin
						if (scl_rise) begin
							state_q <= sda_f_q ? S_IDLE : S_ACK;
							rd_q    <= 1'b1;
						end
					end
					S_RNXT: begin
						// Byte driven while clock is held or low
						tx_q       <= tx_byte;
						sda_oe_out <= ~tx_byte[7];
						cnt_q      <= 4'h0;
						state_q    <= S_RD;
						if (bidx_q != 3'h7) begin
							bidx_q <= bidx_q + 3'h1;
						end
						crc_q <= tx_crc ? `HCP_CRC_INIT : crc_next; // RULE_11
					end
					default: state_q <= S_IDLE;
				endcase
			end
		end
	end

endmodule

// file: hcp_defines.vh
`ifndef HCP_DEFINES_VH
`define HCP_DEFINES_VH

// ****************************************
// Bus address and command codes
// ****************************************
`define HCP_SLAVE_ADDR    7'h70
`define HCP_CMD_SOFT_RST  8'hfe
`define HCP_CMD_HTR_WR    8'he6
`define HCP_CMD_HTR_RD    8'he7
`define HCP_CMD_EID_A     16'hfa0f
`define HCP_CMD_EID_B     16'hfcc9
`define HCP_CMD_MEAS_NH   16'h7ca2
`define HCP_CMD_MEAS_NN   16'h7866
`define HCP_CMD_MEAS_FH   16'h6458
`define HCP_CMD_MEAS_FN   16'h609c
`define HCP_CMD_QRY_NOP   16'h805d
`define HCP_CMD_QRY_ID    16'hefc8
`define HCP_CMD_FW_REV    16'h84f1

// ****************************************
// Checksum, reset, firmware revision and idle byte values
// ****************************************
`define HCP_CRC_INIT      8'hfc
`define HCP_CRC_POLY      8'h31
`define HCP_HEATER_RST    8'h00
`define HCP_FW_REV        8'h10
`define HCP_IDLE_BYTE     8'hff

`endif

// file: hcp_crc8.v
`timescale 1ns/1ns
`include "hcp_defines.vh"

// ****************************************
// One byte step of the checksum, MSB first
// ****************************************
module hcp_crc8 (
	input  wire [7:0] crc_in,
	input  wire [7:0] data_in,
	output reg  [7:0] crc_out
);

	integer i;

	// Eight shift steps unrolled by the loop, no state kept here
	always @* begin
		crc_out = crc_in ^ data_in;
		for (i = 0; i < 8; i = i + 1) begin
			if (crc_out[7]) begin
				crc_out = {crc_out[6:0], 1'b0} ^ `HCP_CRC_POLY;
			end else begin
				crc_out = {crc_out[6:0], 1'b0};
			end
		end
	end

endmodule

// file: hcp_cmd_port_properties.sv
`timescale 1ns/1ns
// ****************************************
// Port checker
// ****************************************
module hcp_cmd_port_props (
	input wire       mclk_in,
	input wire       rst_n_in,
	input wire       scl_in,
	input wire       scl_out,
	input wire       scl_oe_out,
	input wire       sda_out,
	input wire       sda_oe_out,
	input wire       meas_start_out,
	input wire       meas_fast_out,
	input wire       meas_done_in,
	input wire       soft_reset_out,
	input wire [7:0] heater_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	// Open drain: a high drive would fight the pull-up
	open_drain_a: assert property (!scl_out && !sda_out)
		else $error("bus pin driven high");
	// Data may only move while the clock line is low
	data_stable_a: assert property ($changed(sda_oe_out) |-> !scl_in)
		else $error("data changed with clock high");
	start_pulse_a: assert property (meas_start_out |=> !meas_start_out)
		else $error("start pulse too long");
	reset_pulse_a: assert property (soft_reset_out |=> !soft_reset_out)
		else $error("soft reset pulse too long");
	reset_heater_a: assert property (soft_reset_out |-> ##[0:1] heater_out == 8'h00)
		else $error("heater kept after soft reset");
	// A stretch must not outlive the result by more than a few cycles
	stretch_end_a: assert property (meas_done_in && scl_oe_out |-> ##[1:4] !scl_oe_out)
		else $error("stretch not released");
	stretch_start_a: assert property ($rose(scl_oe_out) |-> !$past(scl_in))
		else $error("stretch began with clock high");
	fast_flag_a: assert property ($changed(meas_fast_out) |-> meas_start_out || $past(meas_start_out))
		else $error("speed flag moved without a start");
	cover property (meas_start_out && meas_fast_out);
	cover property (soft_reset_out);
	cover property ($rose(scl_oe_out));
endmodule

bind hcp_cmd_port hcp_cmd_port_props hcp_cmd_port_props_i (
	.mclk_in(mclk_in), .rst_n_in(rst_n_in), .scl_in(scl_in),
	.scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_out(sda_out),
	.sda_oe_out(sda_oe_out), .meas_start_out(meas_start_out),
	.meas_fast_out(meas_fast_out), .meas_done_in(meas_done_in),
	.soft_reset_out(soft_reset_out), .heater_out(heater_out)
);

// file: hcp_host_model.sv
`timescale 1ns/1ns
// ****************************************
// Bus master model, 1 us clock high, 1.2 us clock low
// ****************************************
module hcp_host_model (
	input  wire clk_in,
	input  wire scl_in,
	input  wire sda_in,
	output reg  scl_out,
	output reg  sda_out,
	output reg  tmo_out
);
	integer n, b, tries;
	reg     r;
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
		tmo_out = 1'b0;
		tries = 0;
	end
	// Every change lands just after a clock edge
	task tick(input integer c);
		begin
			repeat (c) @(posedge clk_in);
			#10;
		end
	endtask
	// Honour a stretch, bounded so a stuck line ends the run
	task rise;
		begin
			scl_out = 1'b1;
			for (n = 0; n < 2000 && !scl_in; n = n + 1)
				tick(1);
			if (!scl_in)
				tmo_out = 1'b1;
			tick(10);
		end
	endtask
	// Hold after the fall keeps data moves clear of the edge
	task bit_io(input d);
		begin
			sda_out = d;
			tick(10);
			rise;
			r = sda_in;
			scl_out = 1'b0;
			tick(2);
		end
	endtask
	task start;
		begin
			sda_out = 1'b1;
			tick(10);
			rise;
			sda_out = 1'b0;
			tick(10);
			scl_out = 1'b0;
			tick(2);
		end
	endtask
	task stop;
		begin
			sda_out = 1'b0;
			tick(10);
			rise;
			sda_out = 1'b1;
			tick(20);
		end
	endtask
	task wr(input [7:0] d, output ack);
		begin
			for (b = 7; b >= 0; b = b - 1)
				bit_io(d[b]);
			bit_io(1'b1);
			ack = !r;
		end
	endtask
	task rd(input last, output [7:0] d);
		begin
			for (b = 7; b >= 0; b = b - 1) begin
				bit_io(1'b1);
				d[b] = r;
			end
			bit_io(last);
		end
	endtask
	// Read address, repeated while the device refuses it
	task addr_rd;
		reg ack;
		begin
			tries = 0;
			start;
			wr(8'he1, ack);
			while (!ack && tries < 40) begin
				tries = tries + 1;
				start;
				wr(8'he1, ack);
			end
			if (!ack)
				tmo_out = 1'b1;
		end
	endtask
endmodule

// file: testbench.sv
`timescale 1ns/1ns
// ****************************************
// Command port testbench
// ****************************************
module testbench;
	reg         mclk_in, rst_n_in, done_q, a;
	wire        m_scl, m_sda, tmo, scl_o, scl_oe, sda_o, sda_oe;
	wire        start, fast, srst;
	wire [7:0]  heater;
	wire        scl = m_scl & (scl_oe ? scl_o : 1'b1);
	wire        sda = m_sda & (sda_oe ? sda_o : 1'b1);
	integer     err_count, checked, starts, resets, dly, i, j, holds;
	reg  [7:0]  rx [0:5];
	reg  [7:0]  c;
	reg  [15:0] cd;
	reg  [31:0] id;

	hcp_cmd_port hcp_cmd_port_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.ce_in(1'b1), .scl_in(scl), .sda_in(sda), .scl_out(scl_o),
		.scl_oe_out(scl_oe), .sda_out(sda_o), .sda_oe_out(sda_oe),
		.meas_start_out(start), .meas_fast_out(fast),
		.meas_done_in(done_q), .meas_temp_in(16'h6e3a),
		.meas_hum_in(16'h9b17), .eid_a_in(32'h12345678),
		.eid_b_in(32'h0badcafe), .soft_reset_out(srst),
		.heater_out(heater));
	hcp_host_model hcp_host_model_i (.clk_in(mclk_in), .scl_in(scl),
		.sda_in(sda), .scl_out(m_scl), .sda_out(m_sda), .tmo_out(tmo));

	// Engine stand-in: long enough that a no-hold read is refused
	always @(posedge mclk_in) begin
		done_q <= 1'b0;
		if (start) begin
			starts = starts + 1;
			dly = 300;
		end else if (dly > 0) begin
			dly = dly - 1;
			done_q <= (dly == 1);
		end
		if (srst)
			resets = resets + 1;
		// Cycles in which the device holds the bus clock low
		if (scl_oe)
			holds = holds + 1;
	end
	function [7:0] crc(input [7:0] s, input [7:0] d);
		integer k;
		begin
			crc = s ^ d;
			for (k = 0; k < 8; k = k + 1)
				crc = {crc[6:0], 1'b0} ^ (crc[7] ? 8'h31 : 8'h00);
		end
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("[FAIL] %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	task cmd(input [15:0] code, input two);
		begin
			hcp_host_model_i.start;
			hcp_host_model_i.wr(8'he0, a);
			chk(a, 1);
			if (two)
				hcp_host_model_i.wr(code[15:8], a);
			hcp_host_model_i.wr(code[7:0], a);
		end
	endtask
	task rd(input integer n);
		begin
			hcp_host_model_i.addr_rd;
			for (i = 0; i < n; i = i + 1)
				hcp_host_model_i.rd(i == n - 1, rx[i]);
			hcp_host_model_i.stop;
		end
	endtask
	task sc_addr;
		begin
			hcp_host_model_i.start;
			hcp_host_model_i.wr(8'he2, a);
			chk(a, 0);
			hcp_host_model_i.stop;
		end
	endtask
	task sc_reg;
		begin
			cmd(16'h00e6, 0);
			hcp_host_model_i.wr(8'h5a, a);
			hcp_host_model_i.stop;
			chk(heater, 8'h5a);
			cmd(16'h00e7, 0);
			rd(2);
			chk(rx[0], 8'h5a);
			chk(rx[1], 8'hff);
			cmd(16'h00fe, 0);
			hcp_host_model_i.stop;
			chk(resets, 1);
			chk(heater, 8'h00);
		end
	endtask
	task sc_query;
		begin
			cmd(16'h805d, 1);
			rd(1);
			chk(rx[0], 8'hff);
			cmd(16'hefc8, 1);
			rd(3);
			chk({rx[0], rx[1], rx[2]}, 24'h3c5aa5);
			cmd(16'h84f1, 1);
			rd(1);
			chk(rx[0], 8'h10);
		end
	endtask
	task sc_eid;
		for (j = 0; j < 2; j = j + 1) begin
			id = j ? 32'h0badcafe : 32'h12345678;
			cmd(j ? 16'hfcc9 : 16'hfa0f, 1);
			rd(5);
			c = 8'hfc;
			for (i = 0; i < 4; i = i + 1) begin
				chk(rx[i], id[31 - 8 * i -: 8]);
				c = crc(c, id[31 - 8 * i -: 8]);
			end
			chk(rx[4], c);
		end
	endtask
	// Half a code must start nothing, then every measurement code
	task sc_meas;
		begin
			hcp_host_model_i.start;
			hcp_host_model_i.wr(8'he0, a);
			hcp_host_model_i.wr(8'h7c, a);
			hcp_host_model_i.stop;
			chk(starts, 0);
			for (j = 0; j < 4; j = j + 1) begin
				cd = j == 0 ? 16'h7ca2 : j == 1 ? 16'h7866 :
					j == 2 ? 16'h6458 : 16'h609c;
				holds = 0;
				cmd(cd, 1);
				rd(6);
				chk(starts, j + 1);
				chk(fast, !cd[11]);
				chk(hcp_host_model_i.tries > 0, !cd[10]);
				chk(holds > 0, cd[10]);
				c = crc(crc(8'hfc, 8'h6e), 8'h3a);
				chk({rx[0], rx[1], rx[2]}, {16'h6e3a, c});
				c = crc(crc(8'hfc, 8'h9b), 8'h17);
				chk({rx[3], rx[4], rx[5]}, {16'h9b17, c});
			end
		end
	endtask
	task give_verdict;
		begin
			$display("Checks %0d, mismatches %0d", checked, err_count);
			if (err_count == 0 && checked > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	initial begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end
	initial begin
		rst_n_in = 1'b0;
		done_q = 1'b0;
		{err_count, checked, starts, resets, dly, holds} = 0;
		repeat (20) @(posedge mclk_in);
		#10 rst_n_in = 1'b1;
		repeat (10) @(posedge mclk_in);
		sc_addr;
		sc_reg;
		sc_query;
		sc_eid;
		sc_meas;
		give_verdict;
	end
	// A bus wait that ran out ends the run
	always @(posedge tmo) begin
		err_count = err_count + 1;
		$display("[FAIL] %0t bus wait ran out", $time);
		give_verdict;
	end
endmodule
